// ==== core/spiac_top.sv ====
// Serial audio port with second control register, events and framing
`timescale 1ns/1ns
//
// Contract
// - Sign extend receive words on read when the sign extend bit is set.
// - Frame errors raise an error event only while their enable is set.
// - Receive overflow raises an error event only while its enable is set.
// - Transmit underrun raises an error event only while its enable is set.
// - Ignored overflow is not critical; held receive data is not overwritten.
// - Unignored overflow is critical and stops serial operation.
// - Ignored underrun is not critical; zeros go out until data returns.
// - Unignored underrun is critical and stops serial operation.
// - Audio enable selects audio framing, otherwise plain serial select framing.
// - Mono sends each word on both channels; otherwise words are stereo.
// - Format field picks I2S, left justified, right justified or PCM; right justified is framed exactly as left justified.
// - Audio enable, mono and format accept writes only while module is off.
// - Mono and format take effect only while audio is enabled.
// - Upper control bits read zero; all control bits reset to zero.
module spiac_top
    import spiac_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [DATA_W-1:0] rd_data_o,
    output logic irq_o,
    input wire logic sck_i,
    input wire logic fsync_i,
    input wire logic sdi_i,
    output logic sdo_o
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] rx_extend(input logic [WORD_W-1:0] w,
                                                    input logic sext);
        rx_extend = {{(DATA_W-WORD_W){sext & w[WORD_W-1]}}, w};
    endfunction

    function automatic logic frame_start(input logic aud, input spiac_fmt_e fmt,
                                         input logic f0, input logic f1,
                                         input logic f2);
        if (!aud) begin
            frame_start = f1 & ~f0;
        end else begin
            case (fmt)
                FMT_I2S: frame_start = f1 ^ f2;
                FMT_LEFT: frame_start = f0 ^ f1;
                FMT_RIGHT: frame_start = f0 ^ f1;
                FMT_PCM: frame_start = f0 & ~f1;
                default: frame_start = 1'b0;
            endcase
        end
    endfunction

    function automatic logic right_slot(input logic aud, input spiac_fmt_e fmt,
                                        input logic f0, input logic f1,
                                        input logic cont);
        if (!aud) begin
            right_slot = 1'b0;
        end else begin
            case (fmt)
                FMT_I2S: right_slot = f1;
                FMT_LEFT: right_slot = ~f0;
                FMT_RIGHT: right_slot = ~f0;
                FMT_PCM: right_slot = cont;
                default: right_slot = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic ctl_on_reg;
    logic [DATA_W-1:0] ctl_two_reg;
    logic [EV_W-1:0] status_reg;
    logic [EV_W-1:0] mask_reg;
    logic [WORD_W-1:0] tx_buf_reg;
    logic tx_full_reg;
    logic [WORD_W-1:0] tx_shift_reg;
    logic [WORD_W-1:0] tx_hold_reg;
    logic tx_loaded_reg;
    logic [WORD_W-1:0] rx_shift_reg;
    logic [WORD_W-1:0] rx_buf_reg;
    logic rx_full_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic chan_reg;
    logic pcm_next_reg;
    spiac_state_e state_reg;
    spiac_state_e state_next;
    logic rise;
    logic fall;
    logic sbit;
    logic fs0;
    logic fs1;
    logic fs2;
    logic aud_en;
    logic mono_eff;
    spiac_fmt_e fmt_eff;
    logic run;
    logic rise_ev;
    logic abort_ev;
    logic start;
    logic frm_err;
    logic bit_ev;
    logic [CNT_W-1:0] cnt_inc;
    logic done;
    logic tx_underrun_flag;
    logic rx_overflow_flag;
    logic pop;
    logic idle_load;
    logic crit;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [WORD_W-1:0] rx_word;
    logic [DATA_W-1:0] status_view;
    logic [DATA_W-1:0] rd_mux;
    logic wr_on;
    logic rd_rx;

    // ------------------------------------------------------------
    // Link front end
    // ------------------------------------------------------------
    spiac_link_in u_link_in (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .sck_i(sck_i),
        .fsync_i(fsync_i),
        .sdi_i(sdi_i),
        .rise_o(rise),
        .fall_o(fall),
        .bit_o(sbit),
        .fs0_o(fs0),
        .fs1_o(fs1),
        .fs2_o(fs2)
    );

    // ------------------------------------------------------------
    // Decoded controls and events
    // ------------------------------------------------------------
    always_comb begin
        aud_en = ctl_two_reg[CTL2_AUD_EN_BIT];
        mono_eff = aud_en & ctl_two_reg[CTL2_MONO_BIT];
        fmt_eff = aud_en ? spiac_fmt_e'(ctl_two_reg[CTL2_FMT_MSB:CTL2_FMT_LSB]) : FMT_I2S;
        run = (state_reg == LS_RUN);
        rise_ev = run & rise;
        abort_ev = rise_ev & ~aud_en & fs0 & (cnt_reg != CNT_ZERO);
        start = rise_ev & ~abort_ev
                & (frame_start(aud_en, fmt_eff, fs0, fs1, fs2) | pcm_next_reg);
        frm_err = abort_ev | (start & (cnt_reg != CNT_ZERO));
        bit_ev = rise_ev & ~abort_ev & (start | (cnt_reg != CNT_ZERO));
        cnt_inc = start ? CNT_ONE : cnt_reg + CNT_ONE;
        done = bit_ev & (cnt_inc == WORD_BITS);
        tx_underrun_flag = start & ~tx_loaded_reg;
        rx_overflow_flag = done & rx_full_reg;
        pop = done & (~mono_eff | chan_reg);
        idle_load = run & ~rise & (cnt_reg == CNT_ZERO) & ~tx_loaded_reg & tx_full_reg;
        crit = (rx_overflow_flag & ~ctl_two_reg[CTL2_IGN_ROV_BIT])
               | (tx_underrun_flag & ~ctl_two_reg[CTL2_IGN_TUR_BIT]);
        ev_set[ST_FRM_BIT] = frm_err & ctl_two_reg[CTL2_FRM_EN_BIT];
        ev_set[ST_ROV_BIT] = rx_overflow_flag & ctl_two_reg[CTL2_ROV_EN_BIT];
        ev_set[ST_TUR_BIT] = tx_underrun_flag & ctl_two_reg[CTL2_TUR_EN_BIT];
        ev_clr = (wr_en_i && addr_i == OFF_STATUS) ? wr_data_i[EV_W-1:0] : EV_RESET;
        rx_word = {rx_shift_reg[WORD_W-2:0], sbit};
        wr_on = wr_en_i && (addr_i == OFF_CTL_ONE);
        rd_rx = rd_en_i && (addr_i == OFF_RX_BUF);
    end

    // ------------------------------------------------------------
    // Link state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LS_IDLE: begin
                if (ctl_on_reg) begin
                    state_next = LS_RUN;
                end
            end
            LS_RUN: begin
                if (!ctl_on_reg) begin
                    state_next = LS_IDLE;
                end else if (crit) begin
                    state_next = LS_HALT;
                end
            end
            LS_HALT: begin
                if (!ctl_on_reg) begin
                    state_next = LS_IDLE;
                end
            end
            default: state_next = LS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= LS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctl_on_reg <= 1'b0;
            ctl_two_reg <= CTL2_RESET;
            mask_reg <= EV_RESET;
        end else if (wr_en_i) begin
            if (wr_on) begin
                ctl_on_reg <= wr_data_i[CTL1_ON_BIT];
            end
            if (addr_i == OFF_CTL_TWO) begin
                ctl_two_reg <= (wr_data_i & CTL2_FREE_MASK)
                               | ((ctl_on_reg ? ctl_two_reg : wr_data_i) & CTL2_LOCK_MASK);
            end
            if (addr_i == OFF_MASK) begin
                mask_reg <= wr_data_i[EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky status and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            status_reg <= EV_RESET;
        end else begin
            status_reg <= (status_reg & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_reg & mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_reg <= CNT_ZERO;
            chan_reg <= 1'b0;
            pcm_next_reg <= 1'b0;
        end else if (!run) begin
            cnt_reg <= CNT_ZERO;
            pcm_next_reg <= 1'b0;
        end else if (rise) begin
            if (abort_ev) begin
                cnt_reg <= CNT_ZERO;
            end else if (done) begin
                cnt_reg <= CNT_ZERO;
            end else if (bit_ev) begin
                cnt_reg <= cnt_inc;
            end
            if (start) begin
                chan_reg <= right_slot(aud_en, fmt_eff, fs0, fs1, pcm_next_reg);
            end
            pcm_next_reg <= done & aud_en & (fmt_eff == FMT_PCM) & ~chan_reg;
        end
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_buf_reg <= {WORD_W{1'b0}};
            tx_full_reg <= 1'b0;
            tx_shift_reg <= {WORD_W{1'b0}};
            tx_hold_reg <= {WORD_W{1'b0}};
            tx_loaded_reg <= 1'b0;
        end else begin
            if (wr_en_i && addr_i == OFF_TX_BUF && !tx_full_reg) begin
                tx_buf_reg <= wr_data_i[WORD_W-1:0];
                tx_full_reg <= 1'b1;
            end
            if (!ctl_on_reg) begin
                tx_loaded_reg <= 1'b0;
                tx_shift_reg <= {WORD_W{1'b0}};
            end else if ((pop | idle_load) && tx_full_reg) begin
                tx_shift_reg <= tx_buf_reg;
                tx_hold_reg <= tx_buf_reg;
                tx_full_reg <= 1'b0;
                tx_loaded_reg <= 1'b1;
            end else if (pop) begin
                tx_shift_reg <= {WORD_W{1'b0}};
                tx_loaded_reg <= 1'b0;
            end else if (done) begin
                tx_shift_reg <= tx_loaded_reg ? tx_hold_reg : {WORD_W{1'b0}};
            end else if (run && fall && cnt_reg != CNT_ZERO) begin
                tx_shift_reg <= {tx_shift_reg[WORD_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sdo_o <= 1'b0;
        end else begin
            sdo_o <= run & tx_shift_reg[WORD_W-1];
        end
    end

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_shift_reg <= {WORD_W{1'b0}};
            rx_buf_reg <= {WORD_W{1'b0}};
            rx_full_reg <= 1'b0;
        end else begin
            if (bit_ev) begin
                rx_shift_reg <= rx_word;
            end
            if (done && !rx_full_reg) begin
                rx_buf_reg <= rx_word;
                rx_full_reg <= 1'b1;
            end else if (rd_rx) begin
                rx_full_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        status_view = {DATA_W{1'b0}};
        status_view[EV_W-1:0] = status_reg;
        status_view[ST_RXFULL_BIT] = rx_full_reg;
        status_view[ST_TXEMPTY_BIT] = ~tx_full_reg;
        status_view[ST_HALT_BIT] = (state_reg == LS_HALT);
        case (addr_i)
            OFF_CTL_ONE: rd_mux = {{(DATA_W-1){1'b0}}, ctl_on_reg};
            OFF_CTL_TWO: rd_mux = ctl_two_reg;
            OFF_STATUS: rd_mux = status_view;
            OFF_MASK: rd_mux = {{(DATA_W-EV_W){1'b0}}, mask_reg};
            OFF_TX_BUF: rd_mux = {{(DATA_W-WORD_W){1'b0}}, tx_buf_reg};
            OFF_RX_BUF: rd_mux = rx_extend(rx_buf_reg, ctl_two_reg[CTL2_SIGN_EXT_BIT]);
            default: rd_mux = {DATA_W{1'b0}};
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rd_data_o <= {DATA_W{1'b0}};
        end else if (rd_en_i) begin
            rd_data_o <= rd_mux;
        end else begin
            rd_data_o <= {DATA_W{1'b0}};
        end
    end

endmodule

// ==== core/spiac_pkg.sv ====
// Constants, field layout and types of the audio serial control block
package spiac_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTL_ONE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTL_TWO = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_TX_BUF = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RX_BUF = 8'h14;

    // ------------------------------------------------------------
    // Control one fields
    // ------------------------------------------------------------
    localparam int CTL1_ON_BIT = 0;

    // ------------------------------------------------------------
    // Control two fields
    // ------------------------------------------------------------
    localparam int CTL2_SIGN_EXT_BIT = 15;
    localparam int CTL2_FRM_EN_BIT = 12;
    localparam int CTL2_ROV_EN_BIT = 11;
    localparam int CTL2_TUR_EN_BIT = 10;
    localparam int CTL2_IGN_ROV_BIT = 9;
    localparam int CTL2_IGN_TUR_BIT = 8;
    localparam int CTL2_AUD_EN_BIT = 7;
    localparam int CTL2_MONO_BIT = 3;
    localparam int CTL2_FMT_LSB = 0;
    localparam int CTL2_FMT_MSB = 1;
    localparam logic [DATA_W-1:0] CTL2_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CTL2_FREE_MASK = 32'h0000_9F00;
    localparam logic [DATA_W-1:0] CTL2_LOCK_MASK = 32'h0000_008B;

    // ------------------------------------------------------------
    // Status and mask fields
    // ------------------------------------------------------------
    localparam int ST_FRM_BIT = 0;
    localparam int ST_ROV_BIT = 1;
    localparam int ST_TUR_BIT = 2;
    localparam int ST_RXFULL_BIT = 3;
    localparam int ST_TXEMPTY_BIT = 4;
    localparam int ST_HALT_BIT = 5;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FMT_I2S = 2'b00,
        FMT_LEFT = 2'b01,
        FMT_RIGHT = 2'b10,
        FMT_PCM = 2'b11
    } spiac_fmt_e;

    typedef enum logic [1:0] {
        LS_IDLE = 2'b00,
        LS_RUN = 2'b01,
        LS_HALT = 2'b10
    } spiac_state_e;

endpackage

// ==== core/spiac_link_in.sv ====
// Link input synchroniser and serial clock edge finder
`timescale 1ns/1ns
module spiac_link_in
    import spiac_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic sck_i,
    input wire logic fsync_i,
    input wire logic sdi_i,
    output logic rise_o,
    output logic fall_o,
    output logic bit_o,
    output logic fs0_o,
    output logic fs1_o,
    output logic fs2_o
);

    // ------------------------------------------------------------
    // Two stage synchronisers
    // ------------------------------------------------------------
    logic [1:0] sck_sync_reg;
    logic [1:0] fs_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic sck_last_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sck_sync_reg <= 2'h0;
            fs_sync_reg <= 2'h3;
            sdi_sync_reg <= 2'h0;
            sck_last_reg <= 1'b0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[0], sck_i};
            fs_sync_reg <= {fs_sync_reg[0], fsync_i};
            sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
            sck_last_reg <= sck_sync_reg[1];
        end
    end

    // ------------------------------------------------------------
    // Edge pulses and sampled history
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            bit_o <= 1'b0;
            fs0_o <= 1'b1;
            fs1_o <= 1'b1;
            fs2_o <= 1'b1;
        end else begin
            rise_o <= sck_sync_reg[1] & ~sck_last_reg;
            fall_o <= ~sck_sync_reg[1] & sck_last_reg;
            if (sck_sync_reg[1] & ~sck_last_reg) begin
                bit_o <= sdi_sync_reg[1];
                fs0_o <= fs_sync_reg[1];
                fs1_o <= fs0_o;
                fs2_o <= fs1_o;
            end
        end
    end

endmodule

// ==== sim/spiac_codec_model.sv ====
// Behavioural far-side serial party for the audio serial block
`timescale 1ns/1ns
module spiac_codec_model (
    input wire logic sdo_i,
    output logic sck_o,
    output logic fsync_o,
    output logic sdi_o
);
    logic [15:0] got;

    initial begin
        sck_o = 1'b0;
        fsync_o = 1'b1;
        sdi_o = 1'b0;
        got = 16'h0000;
    end

    // ------------------------------------------------------------
    // One select-framed word, MSB first, after one clock pulse with select high
    // ------------------------------------------------------------
    task automatic frame(input logic [15:0] word, input int nbits);
        #80 sck_o = 1'b1;
        #80 sck_o = 1'b0;
        fsync_o = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            sdi_o = word[i];
            #80 got[i] = sdo_i;
            sck_o = 1'b1;
            #80 sck_o = 1'b0;
        end
        fsync_o = 1'b1;
        sdi_o = ~sdi_o;
    endtask
endmodule

// ==== sim/spiac_top_assertions.sv ====
// Checker of control two, read path and interrupt of the audio serial block
`timescale 1ns/1ns
module spiac_top_assertions
    import spiac_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [DATA_W-1:0] rd_data_o,
    input wire logic irq_o,
    input wire logic sck_i,
    input wire logic fsync_i,
    input wire logic sdi_i,
    input wire logic sdo_o
);
    // ------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------
    logic on_reg;
    logic [DATA_W-1:0] ctl_reg;
    logic [EV_W-1:0] mask_reg;
    logic rd_ctl;
    logic rd_st;
    assign rd_ctl = rd_en_i && addr_i == OFF_CTL_TWO;
    assign rd_st = rd_en_i && addr_i == OFF_STATUS;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            on_reg <= 1'b0;
            ctl_reg <= CTL2_RESET;
            mask_reg <= EV_RESET;
        end else if (wr_en_i) begin
            if (addr_i == OFF_CTL_ONE) begin
                on_reg <= wr_data_i[CTL1_ON_BIT];
            end
            if (addr_i == OFF_CTL_TWO) begin
                ctl_reg <= (wr_data_i & CTL2_FREE_MASK)
                    | ((on_reg ? ctl_reg : wr_data_i) & CTL2_LOCK_MASK);
            end
            if (addr_i == OFF_MASK) begin
                mask_reg <= wr_data_i[EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_ctl_free_bits: assert property (rd_ctl |=>
        (rd_data_o & CTL2_FREE_MASK) == ($past(ctl_reg) & CTL2_FREE_MASK))
        else $error("control two free bits wrong");
    a_ctl_lock_bits: assert property (rd_ctl |=>
        (rd_data_o & CTL2_LOCK_MASK) == ($past(ctl_reg) & CTL2_LOCK_MASK))
        else $error("control two locked bits wrong");
    a_ctl_upper_zero: assert property (rd_ctl |=>
        (rd_data_o & ~(CTL2_FREE_MASK | CTL2_LOCK_MASK)) == 32'h0000_0000)
        else $error("control two unused bits not zero");
    a_rx_sign_ext: assert property (rd_en_i && addr_i == OFF_RX_BUF |=>
        rd_data_o[31:16] == ($past(ctl_reg[15]) ? {16{rd_data_o[15]}} : 16'h0000))
        else $error("receive word extension wrong");
    a_irq_status: assert property (rd_st |=>
        irq_o == ((rd_data_o[2:0] & $past(mask_reg)) != 3'h0))
        else $error("interrupt disagrees with status and mask");
    a_irq_masked: assert property ((mask_reg == 3'h0) [*2] |-> !irq_o)
        else $error("interrupt with all events masked");
    a_unmapped_zero: assert property (rd_en_i && addr_i > OFF_RX_BUF |=>
        rd_data_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_mask_read: assert property (rd_en_i && addr_i == OFF_MASK |=>
        rd_data_o == {29'h0000_0000, $past(mask_reg)})
        else $error("mask read wrong");

    c_irq_seen: cover property (rd_st ##1 irq_o);
    c_locked_write: cover property (on_reg && wr_en_i && addr_i == OFF_CTL_TWO);
    c_neg_rx: cover property (rd_en_i && addr_i == OFF_RX_BUF ##1 rd_data_o[31]);
endmodule

bind spiac_top spiac_top_assertions u_chk (.clk_i, .srst_i, .addr_i, .wr_data_i,
    .wr_en_i, .rd_en_i, .rd_data_o, .irq_o, .sck_i, .fsync_i, .sdi_i, .sdo_o);

// ==== sim/tb_spiac_top.sv ====
// Self-checking bench of the audio serial control block
`timescale 1ns/1ns
module tb_spiac_top
    import spiac_pkg::*;
;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = 8'h00;
    logic [DATA_W-1:0] wr_data_i = 32'h0000_0000;
    logic [DATA_W-1:0] rd_data_o;
    logic irq_o;
    logic sck_i;
    logic fsync_i;
    logic sdi_i;
    logic sdo_o;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] ctl;
    logic [15:0] w;
    logic [15:0] r;
    logic sx;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk_i = ~clk_i;

    spiac_top u_dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .rd_data_o(rd_data_o), .irq_o(irq_o), .sck_i(sck_i), .fsync_i(fsync_i),
        .sdi_i(sdi_i), .sdo_o(sdo_o));
    spiac_codec_model u_codec (.sdo_i(sdo_o), .sck_o(sck_i), .fsync_o(fsync_i),
        .sdi_o(sdi_i));

    // ------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk_i);
        wr_en_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= v;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk_i);
        rd_en_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1 v = rd_data_o;
    endtask

    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        chk_reg(n, e, d);
    endtask

    task automatic link(input logic [15:0] x, input int n);
        u_codec.frame(x, n);
        repeat (8) @(posedge clk_i);
    endtask

    task automatic test_done();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] ctl2_exp(input logic [31:0] p, input logic [31:0] v,
        input logic on);
        return (v & CTL2_FREE_MASK) | ((on ? p : v) & CTL2_LOCK_MASK);
    endfunction

    function automatic logic [31:0] rx_exp(input logic [15:0] x, input logic s);
        return {(s ? {16{x[15]}} : 16'h0000), x};
    endfunction

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        d = $urandom(27705);
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        rchk("ctl_two", OFF_CTL_TWO, CTL2_RESET);
        wr(8'h40, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h40, 32'h0000_0000);
        ctl = CTL2_RESET;
        for (int i = 0; i < 10; i++) begin
            wr(OFF_CTL_ONE, {31'h0000_0000, i > 7});
            d = $urandom();
            d[1:0] = i[1:0];
            d[7] = i[2];
            wr(OFF_CTL_TWO, d);
            ctl = ctl2_exp(ctl, d, i > 7);
            rchk("ctl_two", OFF_CTL_TWO, ctl);
        end
        wr(OFF_CTL_ONE, 32'h0000_0000);
        sx = $urandom();
        ctl = 32'h0000_1F0B | {16'h0000, sx, 15'h0000};
        wr(OFF_CTL_TWO, ctl);
        wr(OFF_MASK, 32'h0000_0007);
        rchk("mask", OFF_MASK, 32'h0000_0007);
        w = $urandom();
        r = $urandom();
        wr(OFF_TX_BUF, {16'h0000, w});
        wr(OFF_CTL_ONE, 32'h0000_0001);
        link(r, 16);
        chk_word("tx_word", w, u_codec.got);
        rchk("rx_buf", OFF_RX_BUF, rx_exp(r, sx));
        r = $urandom();
        link(r, 16);
        chk_word("underrun_word", 16'h0000, u_codec.got);
        rchk("status", OFF_STATUS, 32'h0000_001C);
        w = $urandom();
        wr(OFF_TX_BUF, {16'h0000, w});
        link(16'hA5C3, 16);
        rd(OFF_STATUS, d);
        chk_reg("status_ev", 32'h0000_0006, d & 32'h0000_0027);
        chk_reg("irq", 32'h0000_0001, {31'h0000_0000, irq_o});
        rchk("rx_kept", OFF_RX_BUF, rx_exp(r, sx));
        wr(OFF_STATUS, 32'h0000_0007);
        repeat (2) @(posedge clk_i);
        chk_reg("irq", 32'h0000_0000, {31'h0000_0000, irq_o});
        for (int en = 1; en >= 0; en--) begin
            wr(OFF_CTL_TWO, ctl & ~{19'h0000_0, !en[0], 12'h000});
            wr(OFF_STATUS, 32'h0000_0007);
            link(16'h00FF, 8);
            link(16'h0000, 0);
            rd(OFF_STATUS, d);
            chk_reg("frame_err", en, d & 32'h0000_0001);
        end
        wr(OFF_CTL_ONE, 32'h0000_0000);
        wr(OFF_CTL_TWO, 32'h0000_0000);
        wr(OFF_STATUS, 32'h0000_0007);
        wr(OFF_CTL_ONE, 32'h0000_0001);
        link(16'h1234, 16);
        rd(OFF_STATUS, d);
        chk_reg("halt_tur", 32'h0000_0020, d & 32'h0000_0027);
        wr(OFF_CTL_ONE, 32'h0000_0000);
        rd(OFF_RX_BUF, d);
        wr(OFF_CTL_TWO, 32'h0000_0900);
        wr(OFF_STATUS, 32'h0000_0007);
        wr(OFF_CTL_ONE, 32'h0000_0001);
        link(16'h8001, 16);
        link(16'h7FFE, 16);
        rd(OFF_STATUS, d);
        chk_reg("halt_rov", 32'h0000_0022, d & 32'h0000_0022);
        test_done();
    end
endmodule
